// >>> tb/board_model.sv
// Board side: reset supervisor and pulled-up open-drain reset line
`timescale 1ns/1ns
`default_nettype none
module board_model (
  input wire logic supplies_good,
  input wire logic force_low,
  input wire logic por_line_oe,
  input wire logic por_line_out,
  output logic por_line_in
);
  // Supervisor holds the line low until the rails are good
  assign por_line_in = supplies_good & !force_low & !(por_line_oe & !por_line_out);
endmodule
`default_nettype wire

// >>> tb/por_seq_asserts.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ns
`default_nettype none
`include "por_seq_defs.vh"
module por_seq_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic por_line_in,
  input wire logic por_line_out,
  input wire logic por_line_oe,
  input wire logic core_rail_ok,
  input wire logic io_3v3_rail_ok,
  input wire logic ext_rail_ok,
  input wire logic infra_ready,
  input wire logic [5:0] hardware_config_pins,
  input wire logic infra_start_q,
  input wire logic [`MODE_W-1:0] supply_mode_q,
  input wire logic core_reg_en_q,
  input wire logic io_reg_en_q,
  input wire logic [2:0] cfg_latched_q,
  input wire logic por_effective_n_q,
  input wire logic firmware_run_q,
  input wire logic [7:0] user_freq_mhz_q,
  input wire logic user_code_run_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic ok = core_rail_ok & io_3v3_rail_ok & ext_rail_ok & infra_ready;
  a_drive_on_uv: assert property (!ok [*4] |-> por_line_oe && !por_line_out) else $error("line not low");
  a_release_ok: assert property ($fell(por_line_oe) |-> ok && $past(ok, 2)) else $error("early release");
  a_eff_or: assert property (por_effective_n_q |-> !$past(por_line_oe)) else $error("eff vs oe");
  a_pin_holds: assert property (!por_line_in [*8] |-> ##8 !por_effective_n_q) else $error("pin ignored");
  a_cfg_capture: assert property ($rose(por_effective_n_q) |=> cfg_latched_q == hardware_config_pins[4:2])
    else $error("cfg latch");
  a_fw_gate: assert property ($rose(firmware_run_q) |-> $past(por_effective_n_q)) else $error("fw early");
  a_fw_start: assert property ($rose(por_effective_n_q) |-> ##[1:2] firmware_run_q) else $error("fw late");
  a_user_freq: assert property (user_code_run_q |-> user_freq_mhz_q == `USER_FREQ_MHZ) else $error("freq");
  a_core_reg: assert property (core_reg_en_q |-> supply_mode_q inside {`MODE_SINGLE_5V, `MODE_SINGLE_3V3})
    else $error("core reg");
  a_io_reg: assert property (io_reg_en_q |-> supply_mode_q inside {`MODE_SINGLE_5V, `MODE_EXT_D})
    else $error("io reg");
  a_mode_wait: assert property (core_reg_en_q || io_reg_en_q |-> infra_start_q) else $error("no infra");
endmodule
bind power_on_reset_sequencer por_seq_asserts i_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .por_line_in(por_line_in),
  .por_line_out(por_line_out),
  .por_line_oe(por_line_oe),
  .core_rail_ok(core_rail_ok),
  .io_3v3_rail_ok(io_3v3_rail_ok),
  .ext_rail_ok(ext_rail_ok),
  .infra_ready(infra_ready),
  .hardware_config_pins(hardware_config_pins),
  .infra_start_q(infra_start_q),
  .supply_mode_q(supply_mode_q),
  .core_reg_en_q(core_reg_en_q),
  .io_reg_en_q(io_reg_en_q),
  .cfg_latched_q(cfg_latched_q),
  .por_effective_n_q(por_effective_n_q),
  .firmware_run_q(firmware_run_q),
  .user_freq_mhz_q(user_freq_mhz_q),
  .user_code_run_q(user_code_run_q)
);
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the power-on reset sequencer
`timescale 1ns/1ns
`default_nettype none
`include "por_seq_defs.vh"
module testbench;
  logic ref_clk = 1'h0, reset = 1'h1, infra_ready = 1'h0, firmware_done = 1'h0, test_mode_pin = 1'h0;
  logic low_voltage_detect = 1'h0, glt = 1'h0;
  logic [2:0] rl = 3'h0;
  logic [5:0] hardware_config_pins = 6'h00;
  wire logic [`FILT_CNT_W-1:0] filter_cycles = 4'h6;
  wire logic ext_lvd_ok = low_voltage_detect, standby_lvd_ok = low_voltage_detect, pre_reg_lvd_ok = low_voltage_detect;
  wire logic core_rail_ok = rl[0], io_3v3_rail_ok = rl[1], ext_rail_ok = rl[2];
  wire logic por_line_in, por_line_out, por_line_oe, infra_start_q, mode_valid_q, core_reg_en_q, io_reg_en_q;
  wire logic por_effective_n_q, firmware_run_q, user_code_run_q;
  wire logic [2:0] supply_mode_q, cfg_latched_q;
  wire logic [7:0] user_freq_mhz_q;
  int n_fail = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  power_on_reset_sequencer i_dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .por_line_in(por_line_in),
    .por_line_out(por_line_out),
    .por_line_oe(por_line_oe),
    .core_rail_ok(core_rail_ok),
    .io_3v3_rail_ok(io_3v3_rail_ok),
    .ext_rail_ok(ext_rail_ok),
    .ext_lvd_ok(ext_lvd_ok),
    .standby_lvd_ok(standby_lvd_ok),
    .pre_reg_lvd_ok(pre_reg_lvd_ok),
    .infra_ready(infra_ready),
    .hardware_config_pins(hardware_config_pins),
    .test_mode_pin(test_mode_pin),
    .filter_cycles(filter_cycles),
    .firmware_done(firmware_done),
    .infra_start_q(infra_start_q),
    .supply_mode_q(supply_mode_q),
    .mode_valid_q(mode_valid_q),
    .core_reg_en_q(core_reg_en_q),
    .io_reg_en_q(io_reg_en_q),
    .cfg_latched_q(cfg_latched_q),
    .por_effective_n_q(por_effective_n_q),
    .firmware_run_q(firmware_run_q),
    .user_code_run_q(user_code_run_q),
    .user_freq_mhz_q(user_freq_mhz_q)
  );
  board_model i_board (.supplies_good(&rl), .force_low(glt), .por_line_oe(por_line_oe),
    .por_line_out(por_line_out), .por_line_in(por_line_in));
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Full power-up in one supply mode, then filter, reset hold and rail loss
  task boot(input logic [5:0] pins, input logic [2:0] mode, input logic ce, input logic ie, input int k);
    hardware_config_pins = pins;
    low_voltage_detect = 1'h1;
    wt(8);
    chk(infra_start_q, 1'h1);
    chk(supply_mode_q, mode);
    chk(mode_valid_q, 1'h1);
    chk(core_reg_en_q, ce);
    chk(io_reg_en_q, ie);
    rl = 3'h7;
    wt(8);
    chk(por_line_oe, 1'h1);
    infra_ready = 1'h1;
    // Own release, pin sync and the external filter all lie before the effective release
    wt(16);
    chk(por_line_oe, 1'h0);
    chk(cfg_latched_q, pins[4:2]);
    chk(firmware_run_q, 1'h1);
    firmware_done = 1'h1;
    wt(6);
    chk(user_code_run_q, 1'h1);
    chk(user_freq_mhz_q, `USER_FREQ_MHZ);
    glt = 1'h1;
    wt(4);
    glt = 1'h0;
    wt(4);
    chk(por_effective_n_q, 1'h1);
    glt = 1'h1;
    wt(16);
    chk(por_effective_n_q, 1'h0);
    chk(firmware_run_q, 1'h0);
    chk(core_reg_en_q, ce);
    chk(io_reg_en_q, ie);
    chk(user_code_run_q, 1'h0);
    glt = 1'h0;
    rl[k] = 1'h0;
    wt(6);
    chk(por_line_oe, 1'h1);
    rl = 3'h0;
    infra_ready = 1'h0;
    firmware_done = 1'h0;
    low_voltage_detect = 1'h0;
    wt(4);
    chk(infra_start_q, 1'h0);
    chk(mode_valid_q, 1'h0);
    $display("boot in mode %0d done", mode);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #10;
    reset = 1'h0;
    boot(6'h1F, `MODE_SINGLE_5V, 1'h1, 1'h1, 0);
    boot(6'h0A, `MODE_SINGLE_3V3, 1'h1, 1'h0, 1);
    boot(6'h15, `MODE_EXT_D, 1'h0, 1'h1, 2);
    boot(6'h20, `MODE_EXT_H, 1'h0, 1'h0, 0);
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire

// >>> verilog/por_seq_defs.vh
// Constants and timing figures for the power-on reset sequencer
// Function
// - Effective reset is asserted when the pin is pulled low externally or driven low internally.
// - Drive the reset pin low while any of the three supply monitors reports under-voltage.
// - Release own drive only when all supplies are good and infrastructure is available.
// - Capture configuration pins 3 to 5 on the rising edge of the effective reset.
// - Evaluate supply mode from configuration pins 2:1 and 6 between T1 and T2; the decoded mode depends on pins 2:1 alone, pin 6 never changes it.
// - Bandgap, clocks and mode evaluation wait for low-voltage-detect reset release.
// - At T2 soft-start only the regulators the selected supply mode needs.
// - Regulator enables do not depend on the externally driven reset pin.
// - Start firmware when the reset line releases, never while it is asserted.
// - On firmware completion start user code on the first core at 100 MHz default.
// - Digitally filter the external reset input with 600 to 1200 ns extra delay.
`ifndef POR_SEQ_DEFS_VH
`define POR_SEQ_DEFS_VH
`define CLK_PERIOD_NS 100
`define FILT_DELAY_MIN_NS 600
`define FILT_DELAY_MAX_NS 1200
`define FILT_CYCLES_MIN ((`FILT_DELAY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CYCLES_MAX (`FILT_DELAY_MAX_NS / `CLK_PERIOD_NS)
`define FILT_CNT_W 4
`define MODE_W 3
`define MODE_POS_LO 0
`define MODE_POS_HI 1
`define MODE_POS_6 5
`define CFG_LATCH_LO 2
`define CFG_LATCH_HI 4
`define MODE_SINGLE_5V 3'h3
`define MODE_SINGLE_3V3 3'h2
`define MODE_EXT_D 3'h1
`define MODE_EXT_H 3'h0
`define USER_FREQ_MHZ 8'h64
`endif

// >>> verilog/power_on_reset_sequencer.v
// Power-on reset sequencer: reset line, supply mode, regulator start and boot hand-over
`timescale 1ns/1ns
`default_nettype none
`include "por_seq_defs.vh"
module power_on_reset_sequencer (
  ref_clk,
  reset,
  por_line_in,
  por_line_out,
  por_line_oe,
  core_rail_ok,
  io_3v3_rail_ok,
  ext_rail_ok,
  ext_lvd_ok,
  standby_lvd_ok,
  pre_reg_lvd_ok,
  infra_ready,
  hardware_config_pins,
  test_mode_pin,
  filter_cycles,
  firmware_done,
  infra_start_q,
  supply_mode_q,
  mode_valid_q,
  core_reg_en_q,
  io_reg_en_q,
  cfg_latched_q,
  por_effective_n_q,
  firmware_run_q,
  user_code_run_q,
  user_freq_mhz_q
);
  input wire ref_clk;
  input wire reset;
  input wire por_line_in;
  output reg por_line_out;
  output reg por_line_oe;
  input wire core_rail_ok;
  input wire io_3v3_rail_ok;
  input wire ext_rail_ok;
  input wire ext_lvd_ok;
  input wire standby_lvd_ok;
  input wire pre_reg_lvd_ok;
  input wire infra_ready;
  input wire [5:0] hardware_config_pins;
  input wire test_mode_pin;
  input wire [`FILT_CNT_W-1:0] filter_cycles;
  input wire firmware_done;
  output reg infra_start_q;
  output reg [`MODE_W-1:0] supply_mode_q;
  output reg mode_valid_q;
  output reg core_reg_en_q;
  output reg io_reg_en_q;
  output reg [2:0] cfg_latched_q;
  output reg por_effective_n_q;
  output reg firmware_run_q;
  output reg user_code_run_q;
  output reg [7:0] user_freq_mhz_q;

  // =====================================================
  // Input synchronisers
  // =====================================================
  localparam NSYNC = 15;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  assign async_in = {hardware_config_pins, firmware_done, infra_ready, pre_reg_lvd_ok,
                     standby_lvd_ok, ext_lvd_ok, ext_rail_ok, io_3v3_rail_ok, core_rail_ok, por_line_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  wire pin_low_sync = ~s2_q[0];
  wire rails_ok = s2_q[1] & s2_q[2] & s2_q[3];
  wire lvd_ok = s2_q[4] & s2_q[5] & s2_q[6];
  wire infra_ok = s2_q[7];
  wire fw_done = s2_q[8];
  wire [5:0] cfg = s2_q[14:9];

  // =====================================================
  // External reset filter
  // =====================================================
  wire ext_low;
  reset_pin_filter u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .filter_cycles(filter_cycles),
    .pin_low_sync(pin_low_sync),
    .filt_low_q(ext_low)
  );

  // =====================================================
  // Own drive and effective reset
  // =====================================================
  wire drive_low_d = ~rails_ok | ~infra_ok | ~lvd_ok;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      por_line_out <= 1'b0;
      por_line_oe <= 1'b1;
      por_effective_n_q <= 1'b0;
    end else begin
      por_line_out <= 1'b0;
      por_line_oe <= drive_low_d;
      por_effective_n_q <= ~(ext_low | por_line_oe);
    end
  end

  // =====================================================
  // Start-up sequence
  // =====================================================
  localparam ST_LVD = 5'h01;
  localparam ST_EVAL = 5'h02;
  localparam ST_SOFT = 5'h04;
  localparam ST_FW = 5'h08;
  localparam ST_USER = 5'h10;

  reg [4:0] state_q;
  reg eff_n_prev_q;
  wire eff_rise = por_effective_n_q & ~eff_n_prev_q;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_LVD;
      eff_n_prev_q <= 1'b0;
      infra_start_q <= 1'b0;
      supply_mode_q <= `MODE_EXT_H;
      mode_valid_q <= 1'b0;
      core_reg_en_q <= 1'b0;
      io_reg_en_q <= 1'b0;
      cfg_latched_q <= 3'h0;
      firmware_run_q <= 1'b0;
      user_code_run_q <= 1'b0;
      user_freq_mhz_q <= 8'h00;
    end else begin
      eff_n_prev_q <= por_effective_n_q;
      if (eff_rise) begin
        cfg_latched_q <= cfg[`CFG_LATCH_HI:`CFG_LATCH_LO];
      end
      if (!lvd_ok) begin
        state_q <= ST_LVD;
        infra_start_q <= 1'b0;
        mode_valid_q <= 1'b0;
        core_reg_en_q <= 1'b0;
        io_reg_en_q <= 1'b0;
        firmware_run_q <= 1'b0;
        user_code_run_q <= 1'b0;
      end else if (!por_effective_n_q && (state_q == ST_FW || state_q == ST_USER)) begin
        state_q <= ST_SOFT;
        firmware_run_q <= 1'b0;
        user_code_run_q <= 1'b0;
      end else begin
        case (state_q)
          ST_LVD: begin
            infra_start_q <= 1'b1;
            state_q <= ST_EVAL;
          end
          ST_EVAL: begin
            supply_mode_q <= {cfg[`MODE_POS_6], cfg[`MODE_POS_HI:`MODE_POS_LO]} == 3'h0 ? `MODE_EXT_H :
                             {1'b0, cfg[`MODE_POS_HI:`MODE_POS_LO]};
            mode_valid_q <= 1'b1;
            state_q <= ST_SOFT;
          end
          ST_SOFT: begin
            // Enables depend only on mode, never on the external reset pin
            core_reg_en_q <= supply_mode_q == `MODE_SINGLE_5V || supply_mode_q == `MODE_SINGLE_3V3;
            io_reg_en_q <= supply_mode_q == `MODE_SINGLE_5V || supply_mode_q == `MODE_EXT_D;
            if (por_effective_n_q) begin
              firmware_run_q <= 1'b1;
              state_q <= ST_FW;
            end
          end
          ST_FW: begin
            if (fw_done) begin
              firmware_run_q <= 1'b0;
              user_code_run_q <= 1'b1;
              user_freq_mhz_q <= `USER_FREQ_MHZ;
              state_q <= ST_USER;
            end
          end
          ST_USER: begin
            state_q <= ST_USER;
          end
          default: begin
            state_q <= ST_LVD;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> verilog/reset_pin_filter.v
// Digital glitch filter for the external reset pin input
`timescale 1ns/1ns
`default_nettype none
`include "por_seq_defs.vh"
module reset_pin_filter (
  ref_clk,
  reset,
  filter_cycles,
  pin_low_sync,
  filt_low_q
);
  input wire ref_clk;
  input wire reset;
  input wire [`FILT_CNT_W-1:0] filter_cycles;
  input wire pin_low_sync;
  output reg filt_low_q;

  reg [`FILT_CNT_W-1:0] cnt_q;

  // Output follows the input only after it has been stable for filter_cycles cycles
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= {`FILT_CNT_W{1'b0}};
      filt_low_q <= 1'b1;
    end else if (pin_low_sync == filt_low_q) begin
      cnt_q <= {`FILT_CNT_W{1'b0}};
    end else if (cnt_q >= filter_cycles - 4'h1) begin
      cnt_q <= {`FILT_CNT_W{1'b0}};
      filt_low_q <= pin_low_sync;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire
